// file: nbw_regs.svh
// Purpose: constants for the buffered-write flash sequencer pair
// Assumes: 16-bit parallel bus, 125 MHz core clock
// Notes: offsets and codes shared by both ends
`ifndef NBW_REGS_SVH
`define NBW_REGS_SVH
// command codes
`define NBW_CMD_BUF_SETUP 8'he8
`define NBW_CMD_CONFIRM 8'hd0
`define NBW_CMD_READ_ARRAY 8'hff
`define NBW_CMD_STATUS_READ 8'h70
`define NBW_CMD_CLEAR_STATUS 8'h50
`define NBW_CMD_ERASE_SETUP 8'h20
`define NBW_CMD_SUSPEND 8'hb0
// count limits
`define NBW_COUNT_MAX 16'h01ff
// status word bits
`define NBW_SW_READY 7
`define NBW_SW_SEQ_ERR 4
`define NBW_SW_ERS_ERR 5
// timing (ns) and cycle counts at 8 ns
`define NBW_CLK_NS 8
`define NBW_RESET_LOW_NS 100
`define NBW_RESET_LOW_CYC ((`NBW_RESET_LOW_NS + `NBW_CLK_NS - 1) / `NBW_CLK_NS)
`define NBW_ABORT_US 25
`define NBW_ABORT_CYC ((`NBW_ABORT_US * 1000) / `NBW_CLK_NS)
`define NBW_PWR_RELEASE_UNITS 300
`define NBW_ERS_SUSP_NS 500
`define NBW_ERS_SUSP_CYC ((`NBW_ERS_SUSP_NS + `NBW_CLK_NS - 1) / `NBW_CLK_NS)
// wishbone register offsets of the host controller
`define NBW_OFS_CTRL 8'h00
`define NBW_OFS_ADDR 8'h04
`define NBW_OFS_WDATA 8'h08
`define NBW_OFS_RDATA 8'h0c
`define NBW_OFS_STAT 8'h10
`define NBW_OFS_IRQ_STAT 8'h14
`define NBW_OFS_IRQ_CLR 8'h18
`define NBW_OFS_IRQ_EN 8'h1c
`endif

// file: nbw_pkg.sv
// Purpose: shared types for the buffered-write flash sequencer pair
// Assumes: nothing
// Notes: constants live in nbw_regs.svh
`default_nettype none
package nbw_pkg;
  // device command state
  typedef enum logic [2:0] {
    NBW_DEV_ARRAY,
    NBW_DEV_STATUS,
    NBW_DEV_COUNT,
    NBW_DEV_DATA,
    NBW_DEV_CONFIRM,
    NBW_DEV_BUSY
  } nbw_dev_state_t;
  // host bus cycle state
  typedef enum logic [1:0] {
    NBW_HST_IDLE,
    NBW_HST_SETUP,
    NBW_HST_STROBE,
    NBW_HST_HOLD
  } nbw_hst_state_t;
endpackage : nbw_pkg
`default_nettype wire

// file: nbw_bus_if.sv
// Purpose: parallel flash bus between host controller and device
// Assumes: synchronous model of the pins on core_clk_i
// Notes: data lines are split into out/oe per party, enable low = drive
`default_nettype none
interface nbw_bus_if;
  logic [23:0] addr;       // word address
  logic ce_n;              // chip select, low active
  logic oe_n;              // output enable, low active
  logic we_n;              // write strobe, low active
  logic rst_n;             // device reset, low active
  logic [15:0] host_dq;    // host driven data
  logic host_dq_oe_n;      // host drives dq while low
  logic [15:0] dev_dq;     // device driven data
  logic dev_dq_oe_n;       // device drives dq while low
  modport host (
    output addr, ce_n, oe_n, we_n, rst_n, host_dq, host_dq_oe_n,
    input dev_dq, dev_dq_oe_n
  );
  modport dev (
    input addr, ce_n, oe_n, we_n, rst_n, host_dq, host_dq_oe_n,
    output dev_dq, dev_dq_oe_n
  );
endinterface : nbw_bus_if
`default_nettype wire

// file: nbw_flash_dev.sv
// Purpose: device end, buffered word programming command sequencer
// Assumes: pins arrive asynchronously; strobes pass a 3-stage synchroniser, address and data 2 stages
// Notes: array is a small model memory; program time is a parameter
// Overview of operation
// - count word taken from data bus, 0..1ffh
// - after e8h reads return status word
// - host toggles select or enable between status reads
// - 70h after setup becomes the count
// - buffer programmed from the start address
// - host aligns start address for speed
// - abort when address leaves start block
// - abort sets sequence error, host clears
// - ffh returns device to array read
// - host waits erase-to-suspend delay
// - reset low disables, ignores controls
// - host holds reset low 100 ns
// - reset aborts program within 25 us
// - idle reset completes within reset low time
// - host waits after power before release
// - share processor reset with device reset
`include "nbw_regs.svh"
`default_nettype none
module nbw_flash_dev #(
  parameter int ADDR_W = 12,          // array word address width
  parameter int BLOCK_W = 10,         // word address bits within a block
  parameter int BUF_WORDS = 512,      // write buffer depth
  parameter int PGM_CYC = 64          // cycles per programmed word, minus one
) (
  input wire logic core_clk_i,        // core clock
  input wire logic reset_i,           // synchronous reset, high
  nbw_bus_if.dev bus,                 // flash pins
  output logic busy_o,                // programming in progress
  output logic [7:0] status_o         // status word copy
);
  // --------------------
  // elaboration checks
  // --------------------
  if (BUF_WORDS != 512 || BLOCK_W < 9 || BLOCK_W > ADDR_W
    || ADDR_W > 24) begin : g_geom_chk
    $error("nbw_flash_dev: unsupported geometry");
  end

  // --------------------
  // pin synchronisers
  // --------------------
  logic [2:0] ce_s, oe_s, we_s, rst_s;  // three-stage chains
  logic ce_q, oe_q, we_q, rst_q;        // debounced levels
  logic [23:0] addr_s1, addr_s2;        // address stages
  logic [15:0] dq_s1, dq_s2;            // data stages
  // a level moves only once stage 2 and 3 agree
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ce_s <= 3'h7;
      oe_s <= 3'h7;
      we_s <= 3'h7;
      rst_s <= 3'h0;
      ce_q <= 1'b1;
      oe_q <= 1'b1;
      we_q <= 1'b1;
      rst_q <= 1'b0;
    end else begin
      ce_s <= {ce_s[1:0], bus.ce_n};
      oe_s <= {oe_s[1:0], bus.oe_n};
      we_s <= {we_s[1:0], bus.we_n};
      rst_s <= {rst_s[1:0], bus.rst_n};
      if (ce_s[1] == ce_s[2]) ce_q <= ce_s[2];
      if (oe_s[1] == oe_s[2]) oe_q <= oe_s[2];
      if (we_s[1] == we_s[2]) we_q <= we_s[2];
      if (rst_s[1] == rst_s[2]) rst_q <= rst_s[2];
    end
  end
  // address and data are stable around the strobes
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      addr_s1 <= 24'h0;
      addr_s2 <= 24'h0;
      dq_s1 <= 16'h0;
      dq_s2 <= 16'h0;
    end else begin
      addr_s1 <= bus.addr;
      addr_s2 <= addr_s1;
      dq_s1 <= bus.host_dq;
      dq_s2 <= dq_s1;
    end
  end

  // --------------------
  // strobe edges
  // --------------------
  logic we_d, rd_act_d;                 // previous levels
  logic rd_act;                         // read cycle active
  logic wr_pulse, rd_start;             // single-cycle events
  logic [ADDR_W-1:0] a_q;               // captured word address
  logic [15:0] d_q;                     // captured data word
  assign rd_act = !ce_q && !oe_q;
  // write taken on the rising edge of the strobe with select low
  assign wr_pulse = we_q && !we_d && !ce_q && rst_q;
  assign rd_start = rd_act && !rd_act_d;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      we_d <= 1'b1;
      rd_act_d <= 1'b0;
      a_q <= '0;
      d_q <= 16'h0;
    end else begin
      we_d <= we_q;
      rd_act_d <= rd_act;
      // latch while strobe low so the rising edge sees settled data
      if (!we_q) begin
        a_q <= addr_s2[ADDR_W-1:0];
        d_q <= dq_s2;
      end
    end
  end

  // --------------------
  // array, buffer and sequencer
  // --------------------
  logic [15:0] array_mem [0:(1<<ADDR_W)-1] = '{default: 16'hffff};  // erased
  logic [15:0] buf_mem [0:BUF_WORDS-1];      // write buffer
  nbw_pkg::nbw_dev_state_t state_reg;        // command state
  logic [8:0] count_reg;                     // words still expected, minus one
  logic [8:0] total_reg;                     // latched count n
  logic [8:0] idx_reg;                       // buffer / program index
  logic [ADDR_W-1:0] start_reg;              // start address
  logic [7:0] sw_reg;                        // status word
  logic [15:0] pgm_cnt;                      // per-word timer
  logic [15:0] dout_reg;                     // read data register
  logic same_blk;                            // address within block
  logic [ADDR_W-1:0] pgm_addr;               // address being written
  assign same_blk = a_q[ADDR_W-1:BLOCK_W] == start_reg[ADDR_W-1:BLOCK_W];
  assign pgm_addr = start_reg + ADDR_W'(idx_reg);
  // array contents are not reset: they model nonvolatile cells
  always_ff @(posedge core_clk_i) begin
    if (state_reg == nbw_pkg::NBW_DEV_BUSY && pgm_cnt == 16'h0 && rst_q)
      array_mem[pgm_addr] <= array_mem[pgm_addr] & buf_mem[idx_reg];
    if (state_reg == nbw_pkg::NBW_DEV_DATA && wr_pulse)
      buf_mem[9'(total_reg - count_reg)] <= d_q;
  end
  // command decoding; any reset aborts at once, well inside 25 us
  always_ff @(posedge core_clk_i) begin
    if (reset_i || !rst_q) begin
      state_reg <= nbw_pkg::NBW_DEV_ARRAY;
      count_reg <= 9'h0;
      total_reg <= 9'h0;
      idx_reg <= 9'h0;
      start_reg <= '0;
      sw_reg <= 8'h80;
      pgm_cnt <= 16'h0;
    end else begin
      case (state_reg)
        nbw_pkg::NBW_DEV_ARRAY, nbw_pkg::NBW_DEV_STATUS: begin
          if (wr_pulse) begin
            case (d_q[7:0])
              `NBW_CMD_BUF_SETUP: begin
                start_reg <= a_q;
                state_reg <= nbw_pkg::NBW_DEV_COUNT;
              end
              `NBW_CMD_READ_ARRAY:
                state_reg <= nbw_pkg::NBW_DEV_ARRAY;
              `NBW_CMD_STATUS_READ: state_reg <= nbw_pkg::NBW_DEV_STATUS;
              `NBW_CMD_CLEAR_STATUS: sw_reg <= 8'h80;
              default: state_reg <= state_reg;
            endcase
          end
        end
        nbw_pkg::NBW_DEV_COUNT: begin
          // any word up to 1ffh written inside the start block, 70h included, is the count
          if (wr_pulse) begin
            if (d_q > `NBW_COUNT_MAX || !same_blk) begin
              sw_reg[`NBW_SW_SEQ_ERR] <= 1'b1;
              sw_reg[`NBW_SW_ERS_ERR] <= 1'b1;
              state_reg <= nbw_pkg::NBW_DEV_STATUS;
            end else begin
              total_reg <= d_q[8:0];
              count_reg <= d_q[8:0];
              state_reg <= nbw_pkg::NBW_DEV_DATA;
            end
          end
        end
        nbw_pkg::NBW_DEV_DATA: begin
          if (wr_pulse) begin
            if (!same_blk) begin
              sw_reg[`NBW_SW_SEQ_ERR] <= 1'b1;
              sw_reg[`NBW_SW_ERS_ERR] <= 1'b1;
              state_reg <= nbw_pkg::NBW_DEV_STATUS;
            end else if (count_reg == 9'h0) begin
              state_reg <= nbw_pkg::NBW_DEV_CONFIRM;
            end else begin
              count_reg <= count_reg - 9'h1;
            end
          end
        end
        nbw_pkg::NBW_DEV_CONFIRM: begin
          if (wr_pulse) begin
            if (d_q[7:0] == `NBW_CMD_CONFIRM && same_blk) begin
              sw_reg[`NBW_SW_READY] <= 1'b0;
              idx_reg <= 9'h0;
              pgm_cnt <= 16'(PGM_CYC);
              state_reg <= nbw_pkg::NBW_DEV_BUSY;
            end else begin
              sw_reg[`NBW_SW_SEQ_ERR] <= 1'b1;
              sw_reg[`NBW_SW_ERS_ERR] <= 1'b1;
              state_reg <= nbw_pkg::NBW_DEV_STATUS;
            end
          end
        end
        nbw_pkg::NBW_DEV_BUSY: begin
          // commands during programming are ignored
          if (pgm_cnt != 16'h0) begin
            pgm_cnt <= pgm_cnt - 16'h1;
          end else if (idx_reg == total_reg) begin
            sw_reg[`NBW_SW_READY] <= 1'b1;
            state_reg <= nbw_pkg::NBW_DEV_STATUS;
          end else begin
            idx_reg <= idx_reg + 9'h1;
            pgm_cnt <= 16'(PGM_CYC);
          end
        end
        default: state_reg <= nbw_pkg::NBW_DEV_ARRAY;
      endcase
    end
  end

  // --------------------
  // read path
  // --------------------
  // status refreshes only at the start of a read, hence the toggle
  always_ff @(posedge core_clk_i) begin
    if (reset_i || !rst_q) begin
      dout_reg <= 16'h0;
    end else if (rd_start) begin
      if (state_reg == nbw_pkg::NBW_DEV_ARRAY)
        dout_reg <= array_mem[addr_s2[ADDR_W-1:0]];
      else
        dout_reg <= {8'h00, sw_reg};
    end
  end
  assign bus.dev_dq = dout_reg;
  assign bus.dev_dq_oe_n = !(rd_act && rd_act_d && rst_q);
  assign busy_o = state_reg == nbw_pkg::NBW_DEV_BUSY;
  assign status_o = sw_reg;
endmodule : nbw_flash_dev
`default_nettype wire

// file: nbw_host_ctrl.sv
// Purpose: host end, wishbone controlled flash bus cycle engine
// Assumes: software sequences commands; engine times each bus cycle
// Notes: each access holds its strobe for STROBE_CYC + 1 cycles
`include "nbw_regs.svh"
`default_nettype none
module nbw_host_ctrl #(
  parameter int STROBE_CYC = 8,       // strobe low cycles per access, minus one
  parameter int RESET_CYC = `NBW_RESET_LOW_CYC  // reset pulse length
) (
  input wire logic core_clk_i,        // core clock
  input wire logic reset_i,           // synchronous reset, high
  input wire logic wb_cyc_i,          // wishbone cycle
  input wire logic wb_stb_i,          // wishbone strobe
  input wire logic wb_we_i,           // wishbone write
  input wire logic [7:0] wb_adr_i,    // wishbone byte address
  input wire logic [3:0] wb_sel_i,    // wishbone byte selects
  input wire logic [31:0] wb_dat_i,   // wishbone write data
  output logic [31:0] wb_dat_o,       // wishbone read data
  output logic wb_ack_o,              // wishbone acknowledge
  output logic irq_o,                 // level interrupt
  nbw_bus_if.host bus                 // flash pins
);
  // read data needs about six cycles through the device synchroniser
  if (STROBE_CYC < 6 || STROBE_CYC > 255 || RESET_CYC < 13
    || RESET_CYC > 255) begin : g_len_chk
    $error("nbw_host_ctrl: strobe or reset length out of range");
  end
  // --------------------
  // registers and engine state
  // --------------------
  nbw_pkg::nbw_hst_state_t st_reg;    // bus cycle state
  logic [7:0] tmr_reg;                // phase timer
  logic op_wr_reg;                    // current access is a write
  logic [23:0] addr_reg;              // flash word address
  logic [15:0] wdata_reg;             // write data
  logic [15:0] rdata_reg;             // last read data
  logic [1:0] irq_st_reg, irq_en_reg; // done, reset-done
  logic rst_act_reg;                  // reset pulse active
  logic [7:0] rst_cnt;                // reset pulse timer
  logic wb_hit;                       // new wishbone request
  logic go_rd, go_wr, go_rst;         // control register strobes
  logic done_ev, rst_done_ev;         // events
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign go_wr = wb_hit && wb_we_i && wb_adr_i == `NBW_OFS_CTRL
    && wb_sel_i[0] && wb_dat_i[0];
  assign go_rd = wb_hit && wb_we_i && wb_adr_i == `NBW_OFS_CTRL
    && wb_sel_i[0] && wb_dat_i[1];
  assign go_rst = wb_hit && wb_we_i && wb_adr_i == `NBW_OFS_CTRL
    && wb_sel_i[0] && wb_dat_i[2];
  // --------------------
  // wishbone slave, one wait-free answer per request
  // --------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      addr_reg <= 24'h0;
      wdata_reg <= 16'h0;
      irq_en_reg <= 2'h0;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= 32'h0;
      if (wb_hit && wb_we_i) begin
        if (wb_adr_i == `NBW_OFS_ADDR) addr_reg <= wb_dat_i[23:0];
        if (wb_adr_i == `NBW_OFS_WDATA) wdata_reg <= wb_dat_i[15:0];
        if (wb_adr_i == `NBW_OFS_IRQ_EN) irq_en_reg <= wb_dat_i[1:0];
      end else if (wb_hit) begin
        case (wb_adr_i)
          `NBW_OFS_ADDR: wb_dat_o <= {8'h00, addr_reg};
          `NBW_OFS_WDATA: wb_dat_o <= {16'h0, wdata_reg};
          `NBW_OFS_RDATA: wb_dat_o <= {16'h0, rdata_reg};
          `NBW_OFS_STAT: wb_dat_o <= {30'h0, rst_act_reg,
            st_reg != nbw_pkg::NBW_HST_IDLE};
          `NBW_OFS_IRQ_STAT: wb_dat_o <= {30'h0, irq_st_reg};
          `NBW_OFS_IRQ_EN: wb_dat_o <= {30'h0, irq_en_reg};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end
  // --------------------
  // bus cycle engine: setup, strobe low, hold with strobe high
  // --------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_reg <= nbw_pkg::NBW_HST_IDLE;
      tmr_reg <= 8'h0;
      op_wr_reg <= 1'b0;
      rdata_reg <= 16'h0;
    end else begin
      case (st_reg)
        nbw_pkg::NBW_HST_IDLE: begin
          // select is released between accesses, refreshing status
          if ((go_wr || go_rd) && !rst_act_reg) begin
            op_wr_reg <= go_wr;
            tmr_reg <= 8'(STROBE_CYC);
            st_reg <= nbw_pkg::NBW_HST_SETUP;
          end
        end
        nbw_pkg::NBW_HST_SETUP: st_reg <= nbw_pkg::NBW_HST_STROBE;
        nbw_pkg::NBW_HST_STROBE: begin
          if (tmr_reg == 8'h0) begin
            if (!op_wr_reg) rdata_reg <= bus.dev_dq;
            tmr_reg <= 8'(STROBE_CYC);
            st_reg <= nbw_pkg::NBW_HST_HOLD;
          end else begin
            tmr_reg <= tmr_reg - 8'h1;
          end
        end
        nbw_pkg::NBW_HST_HOLD: begin
          if (tmr_reg == 8'h0) st_reg <= nbw_pkg::NBW_HST_IDLE;
          else tmr_reg <= tmr_reg - 8'h1;
        end
        default: st_reg <= nbw_pkg::NBW_HST_IDLE;
      endcase
    end
  end
  assign done_ev = st_reg == nbw_pkg::NBW_HST_HOLD && tmr_reg == 8'h0;
  // --------------------
  // device reset pulse, at least the reset low time
  // --------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rst_act_reg <= 1'b1;
      rst_cnt <= 8'(RESET_CYC);
    end else if (go_rst && st_reg == nbw_pkg::NBW_HST_IDLE) begin
      rst_act_reg <= 1'b1;
      rst_cnt <= 8'(RESET_CYC);
    end else if (rst_cnt != 8'h0) begin
      rst_cnt <= rst_cnt - 8'h1;
    end else begin
      rst_act_reg <= 1'b0;
    end
  end
  assign rst_done_ev = rst_act_reg && rst_cnt == 8'h0;
  // --------------------
  // interrupt status: set wins over clear
  // --------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      irq_st_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (i == 0 ? done_ev : rst_done_ev) irq_st_reg[i] <= 1'b1;
        else if (wb_hit && wb_we_i && wb_adr_i == `NBW_OFS_IRQ_CLR
          && wb_dat_i[i]) irq_st_reg[i] <= 1'b0;
      end
    end
  end
  assign irq_o = |(irq_st_reg & irq_en_reg);
  // --------------------
  // pins
  // --------------------
  assign bus.addr = addr_reg;
  assign bus.ce_n = st_reg == nbw_pkg::NBW_HST_IDLE;
  assign bus.we_n = !(op_wr_reg && st_reg == nbw_pkg::NBW_HST_STROBE);
  assign bus.oe_n = !(!op_wr_reg && st_reg == nbw_pkg::NBW_HST_STROBE);
  assign bus.rst_n = !rst_act_reg;
  assign bus.host_dq = wdata_reg;
  assign bus.host_dq_oe_n = !(op_wr_reg && st_reg != nbw_pkg::NBW_HST_IDLE);
endmodule : nbw_host_ctrl
`default_nettype wire

// file: nbw_bus_properties.sv
// Purpose: concurrent checks on the flash bus between host and device
// Assumes: one clock domain, synchronous active-high reset
// Notes: sees only the interface signals, instantiated beside them
`default_nettype none
module nbw_bus_properties #(
  parameter int STROBE_CYC = 8        // strobe low cycles per access, minus one
) (
  input wire logic core_clk_i,        // core clock
  input wire logic reset_i,           // synchronous reset, high
  input wire logic [23:0] addr,       // word address
  input wire logic ce_n,              // chip select, low active
  input wire logic oe_n,              // output enable, low active
  input wire logic we_n,              // write strobe, low active
  input wire logic rst_n,             // device reset, low active
  input wire logic [15:0] host_dq,    // host driven data
  input wire logic host_dq_oe_n,      // host drives while low
  input wire logic [15:0] dev_dq,     // device driven data
  input wire logic dev_dq_oe_n        // device drives while low
);
  // --------------------
  // run-length helpers
  // --------------------
  localparam int RST_MIN = 13;        // 100 ns at 8 ns, rounded up
  logic [7:0] low_cnt;                // cycles the reset pin stayed low
  logic [7:0] we_cnt;                 // cycles the write strobe stayed low
  // cleared by reset_i so an unknown start never sticks in the sum
  always_ff @(posedge core_clk_i) begin
    if (reset_i || rst_n) begin
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= low_cnt + 8'h01;
    end
  end
  // strobe width counter, zero while the strobe is high
  always_ff @(posedge core_clk_i) begin
    if (reset_i || we_n) begin
      we_cnt <= 8'h00;
    end else begin
      we_cnt <= we_cnt + 8'h01;
    end
  end
  // --------------------
  // properties
  // --------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  a_rst_pulse_len: assert property (
    $rose(rst_n) |-> low_cnt >= RST_MIN)
    else $error("reset pin pulse too short");
  a_reset_quiets_dev: assert property ((!rst_n)[*4] |-> dev_dq_oe_n)
    else $error("device drives data while held in reset");
  a_strobe_in_select: assert property ((!we_n || !oe_n) |-> !ce_n)
    else $error("strobe low outside chip select");
  a_access_bounded: assert property (
    $fell(ce_n) |-> ##[4:30] $rose(ce_n))
    else $error("chip select not toggled between accesses");
  a_write_width: assert property (
    $rose(we_n) |-> we_cnt == STROBE_CYC + 1)
    else $error("write strobe width wrong");
  a_write_data_held: assert property (
    !we_n && !$past(we_n) |->
    $stable(host_dq) && $stable(addr) && !host_dq_oe_n)
    else $error("write data moved under the strobe");
  a_read_release: assert property (
    $rose(oe_n) |-> ##[0:8] dev_dq_oe_n)
    else $error("device kept driving after read");
  a_read_stable: assert property (
    !dev_dq_oe_n && !$past(dev_dq_oe_n) |-> $stable(dev_dq))
    else $error("read data changed without a toggle");
  c_write: cover property ($rose(we_n));
  c_read: cover property ($fell(dev_dq_oe_n));
  c_reset: cover property ($rose(rst_n));
endmodule : nbw_bus_properties
`default_nettype wire

// file: test_nor_buffered_write_and_reset.sv
// Purpose: self-checking bench for the host and device pair
// Assumes: blank array reads all ones, program time shortened
// Notes: drives through the wishbone registers, also checks device status_o and busy_o
`include "nbw_regs.svh"
`default_nettype none
module test_nor_buffered_write_and_reset;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ERASED = 16'hffff; // blank array word
  logic core_clk_i, reset_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic irq_o, busy_o;
  logic [7:0] wb_adr_i, status_o;
  logic [31:0] wb_dat_i, wb_dat_o, rd; // rd holds wb_dat_o after the last wishbone cycle: read data, or zero after a write
  int err_total, n_checks;
  nbw_bus_if bus_if();
  nbw_host_ctrl nbw_host_ctrl_inst (.core_clk_i, .reset_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .irq_o, .bus(bus_if));
  nbw_flash_dev #(.PGM_CYC(4)) nbw_flash_dev_inst (.core_clk_i, .reset_i,
    .bus(bus_if), .busy_o, .status_o);
  nbw_bus_properties nbw_bus_properties_inst (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .addr(bus_if.addr),
    .ce_n(bus_if.ce_n), .oe_n(bus_if.oe_n), .we_n(bus_if.we_n),
    .rst_n(bus_if.rst_n), .host_dq(bus_if.host_dq),
    .host_dq_oe_n(bus_if.host_dq_oe_n), .dev_dq(bus_if.dev_dq),
    .dev_dq_oe_n(bus_if.dev_dq_oe_n));
  // --------------------
  // reporting and bus tasks
  // --------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  task automatic tmo();
    err_total++;
    $display("MISMATCH at %0t: wait ran out", $time);
    end_of_test();
  endtask : tmo
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle; the request stands until ack is seen
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk_i);
    if (n >= 100) tmo();
  endtask : wb
  // one flash bus access, waits for its done flag then clears it
  task automatic fl(input logic we, input logic [23:0] a,
    input logic [15:0] d);
    int n;
    wb(1'b1, `NBW_OFS_ADDR, {8'h00, a});
    if (we) wb(1'b1, `NBW_OFS_WDATA, {16'h0000, d});
    wb(1'b1, `NBW_OFS_CTRL, we ? 32'h1 : 32'h2);
    n = 0;
    do begin
      wb(1'b0, `NBW_OFS_IRQ_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 50);
    if (n >= 50) tmo();
    wb(1'b1, `NBW_OFS_IRQ_CLR, 32'h1);
    if (!we) wb(1'b0, `NBW_OFS_RDATA, 32'h0);
  endtask : fl
  // no flash access may start while the reset pulse is active
  task automatic wait_rst_done();
    int n;
    n = 0;
    do begin
      wb(1'b0, `NBW_OFS_STAT, 32'h0);
      n++;
    end while (rd[1] !== 1'b0 && n < 50);
    if (n >= 50) tmo();
  endtask : wait_rst_done
  // --------------------
  // scenarios
  // --------------------
  task automatic t_start();
    wait_rst_done();
    chk({24'h0, status_o}, 32'h80);
    wb(1'b0, 8'h40, 32'hffff_ffff);
    chk(rd, 32'h0);
    fl(1'b0, 24'h400, 16'h0);
    chk(rd[15:0], ERASED);
    $display("test start done");
  endtask : t_start
  // a status-read code after setup is taken as a count of 70h
  task automatic t_buffered();
    fl(1'b1, 24'h400, {8'h00, `NBW_CMD_BUF_SETUP});
    fl(1'b0, 24'h400, 16'h0);
    chk({24'h0, rd[7:0]}, 32'h80);
    fl(1'b1, 24'h400, {8'h00, `NBW_CMD_STATUS_READ});
    for (int i = 0; i <= 32'h70; i++) fl(1'b1, 24'h400 + i, 16'h1200 + i);
    fl(1'b1, 24'h400, {8'h00, `NBW_CMD_CONFIRM});
    for (int n = 0; n <= 100; n++) begin
      fl(1'b0, 24'h400, 16'h0);
      if (rd[7] === 1'b1) break;
      if (n == 100) tmo();
    end
    chk({24'h0, rd[7:0]}, 32'h80);
    fl(1'b1, 24'h400, {8'h00, `NBW_CMD_READ_ARRAY});
    fl(1'b0, 24'h400, 16'h0);
    chk(rd[15:0], 16'h1200);
    fl(1'b0, 24'h470, 16'h0);
    chk(rd[15:0], 16'h1270);
    fl(1'b0, 24'h471, 16'h0);
    chk(rd[15:0], ERASED);
    $display("test buffered done");
  endtask : t_buffered
  // second data word leaves the start block
  task automatic t_abort();
    fl(1'b1, 24'h800, {8'h00, `NBW_CMD_BUF_SETUP});
    fl(1'b1, 24'h800, 16'h0001);
    fl(1'b1, 24'h800, 16'h5a5a);
    fl(1'b1, 24'h000, 16'h5a5a);
    chk({24'h0, status_o}, 32'hb0);
    fl(1'b1, 24'h800, {8'h00, `NBW_CMD_CLEAR_STATUS});
    chk({24'h0, status_o}, 32'h80);
    fl(1'b1, 24'h800, {8'h00, `NBW_CMD_READ_ARRAY});
    fl(1'b0, 24'h800, 16'h0);
    chk(rd[15:0], ERASED);
    $display("test abort done");
  endtask : t_abort
  // masked, enabled, then cleared access-done interrupt
  task automatic t_irq();
    wb(1'b1, `NBW_OFS_CTRL, 32'h2);
    repeat (20) @(posedge core_clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wb(1'b1, `NBW_OFS_IRQ_EN, 32'h1);
    chk({31'h0, irq_o}, 32'h1);
    wb(1'b1, `NBW_OFS_IRQ_CLR, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    wb(1'b1, `NBW_OFS_IRQ_EN, 32'h0);
    $display("test irq done");
  endtask : t_irq
  // full 1ffh count, then a reset pulse in mid-program
  task automatic t_hwreset();
    int n;
    fl(1'b1, 24'h000, {8'h00, `NBW_CMD_BUF_SETUP});
    fl(1'b1, 24'h000, `NBW_COUNT_MAX);
    for (int i = 0; i < 32'h200; i++) fl(1'b1, 24'h000 + i, 16'h0000);
    fl(1'b1, 24'h000, {8'h00, `NBW_CMD_CONFIRM});
    chk({31'h0, busy_o}, 32'h1);
    wb(1'b1, `NBW_OFS_CTRL, 32'h4);
    n = 0;
    while (busy_o !== 1'b0 && n < `NBW_ABORT_CYC) begin
      @(posedge core_clk_i);
      n++;
    end
    chk({31'h0, busy_o}, 32'h0);
    wait_rst_done();
    chk({24'h0, status_o}, 32'h80);
    fl(1'b0, 24'h1ff, 16'h0);
    chk(rd[15:0], ERASED);
    $display("test hwreset done");
  endtask : t_hwreset
  // --------------------
  // clock and main sequence
  // --------------------
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  initial begin
    reset_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    err_total = 0;
    n_checks = 0;
    repeat (6) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    t_start();
    t_buffered();
    t_abort();
    t_irq();
    t_hwreset();
    end_of_test();
  end
endmodule : test_nor_buffered_write_and_reset
`default_nettype wire
